// file: hw/hpm_defines.vh
`ifndef HPM_DEFINES_VH
`define HPM_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define HPM_BUS_SELECT_ADDR  16'h6C00
`define HPM_TIMEOUT_ADDR     16'h6C04
`define HPM_IRQ_STATUS_ADDR  16'h6C08
`define HPM_IRQ_MASK_ADDR    16'h6C0C
`define HPM_PERIPH_BASE      16'h7000
// ----------------------------------------
// fields
// ----------------------------------------
`define HPM_PAR_MODE_BIT     0
`define HPM_SER_MODE_BIT     2
`define HPM_RSV_BIT          3
`define HPM_TO_EN_BIT        0
`define HPM_IRQ_ERR_BIT      0
`define HPM_IRQ_WRITE_BIT    1
`define HPM_PSEL_SERIAL      2'h0
`define HPM_PSEL_UART        2'h1
`define HPM_PSEL_MEMIF       2'h2
`endif

// file: hw/hpm_sync.v
`timescale 1ns/1ns
// ----------------------------------------
// three-stage pin synchroniser, agreed level
// ----------------------------------------
module hpm_sync (
  // clock
  input  wire hclk,
  // pin and result
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // no reset: the strap is sampled while reset is held
  always @(posedge hclk) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// file: hw/hpm_clk_gate.v
`timescale 1ns/1ns
// ----------------------------------------
// clock gate, enable held in a negedge flop
// ----------------------------------------
module hpm_clk_gate (
  // clock
  input  wire hclk,
  // enable and gated clock
  input  wire enable,
  output wire gclk
);
  reg en_q;
  // enable moves only while the clock is low, so no glitch
  always @(negedge hclk) begin
    en_q <= enable;
  end
  assign gclk = hclk & en_q;
endmodule

// file: hw/hpm_pin_mux.v
`timescale 1ns/1ns
`include "hpm_defines.vh"
module hpm_pin_mux (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // straps
  input  wire        parallel_mode_strap,
  input  wire        serial_mode_strap,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [15:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // interrupt
  output wire        irq,
  // host pins
  input  wire [7:0]  host_data_pins_in,
  output reg  [7:0]  host_data_pins_out,
  output reg  [7:0]  host_data_pins_oe_n,
  input  wire        host_control_pin_zero,
  input  wire        host_control_pin_one,
  // host port core side
  input  wire [7:0]  host_port_data_out,
  input  wire        host_port_data_drive,
  output reg  [7:0]  host_port_data_in,
  output reg         host_address_strobe,
  output reg         host_byte_identify,
  output wire        host_port_enable,
  output wire        host_port_multiplexed,
  output wire        host_port_on_parallel,
  // parallel general io core side, bits 45:36
  input  wire [9:0]  parallel_general_io_out,
  input  wire [9:0]  parallel_general_io_oe_n,
  output reg  [9:0]  parallel_general_io_in,
  // parallel pin function
  output wire        memif_32bit_mode,
  // serial pins
  input  wire [3:0]  serial_pins_in,
  output reg  [3:0]  serial_pins_out,
  output reg  [3:0]  serial_pins_oe_n,
  // third serial port core side
  input  wire        serial_transmit_clock_out,
  input  wire        serial_transmit_clock_oe_n,
  input  wire        serial_receive_clock_out,
  input  wire        serial_receive_clock_oe_n,
  input  wire        serial_transmit_frame_sync_out,
  input  wire        serial_transmit_frame_sync_oe_n,
  input  wire        serial_receive_frame_sync_out,
  input  wire        serial_receive_frame_sync_oe_n,
  output reg  [3:0]  serial_port2_in,
  // uart and gpio core side
  input  wire        uart_tx,
  output reg         uart_rx,
  input  wire        general_io_three_out,
  input  wire        general_io_three_oe_n,
  output reg         general_io_three_in,
  input  wire        general_io_five_out,
  input  wire        general_io_five_oe_n,
  output reg         general_io_five_in,
  // module clocks and enables
  output wire        serial_port2_clk,
  output wire        uart_clk,
  output wire        memif_clk,
  output wire        serial_port2_enable,
  output wire        uart_enable
);
  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  wire par_sync;
  wire ser_sync;
  reg  armed_q;
  reg  par_mode_q;
  reg  ser_mode_q;
  reg  rsv_q;
  reg  to_en_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_mask_q;

  hpm_sync u_par_sync (
    .hclk    (hclk),
    .pin_in  (parallel_mode_strap),
    .level_q (par_sync)
  );
  hpm_sync u_ser_sync (
    .hclk    (hclk),
    .pin_in  (serial_mode_strap),
    .level_q (ser_sync)
  );

  // ----------------------------------------
  // ahb-lite address phase
  // ----------------------------------------
  reg        dp_valid_q;
  reg        dp_write_q;
  reg [15:0] dp_addr_q;
  reg        err_q;
  reg        err_second_q;
  wire       a_valid = hsel & hready & htrans[1];
  wire       is_periph = (haddr >= `HPM_PERIPH_BASE);
  wire [1:0] psel = haddr[9:8];
  reg        desel;

  always @* begin
    case (psel)
      `HPM_PSEL_SERIAL: desel = ~ser_mode_q;
      `HPM_PSEL_UART:   desel = ser_mode_q;
      `HPM_PSEL_MEMIF:  desel = ~par_mode_q;
      default:          desel = 1'b0;
    endcase
  end

  wire a_err = a_valid & is_periph & desel & to_en_q;
  wire wr_bus = dp_valid_q & dp_write_q;
  wire wr_bus_select_register = wr_bus & (dp_addr_q == `HPM_BUS_SELECT_ADDR);
  wire wr_to = wr_bus & (dp_addr_q == `HPM_TIMEOUT_ADDR);
  wire wr_stat = wr_bus & (dp_addr_q == `HPM_IRQ_STATUS_ADDR);
  wire wr_mask = wr_bus & (dp_addr_q == `HPM_IRQ_MASK_ADDR);

  // two-cycle error response
  assign hreadyout = ~err_q | err_second_q;
  assign hresp     = err_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q   <= 1'b0;
      dp_write_q   <= 1'b0;
      dp_addr_q    <= 16'h0000;
      err_q        <= 1'b0;
      err_second_q <= 1'b0;
    end else begin
      if (err_q & ~err_second_q) begin
        err_second_q <= 1'b1;
      end else begin
        err_second_q <= 1'b0;
        err_q        <= a_err;
        dp_valid_q   <= a_valid & ~a_err;
        dp_write_q   <= hwrite;
        dp_addr_q    <= haddr;
      end
    end
  end

  // ----------------------------------------
  // register next values
  // ----------------------------------------
  reg        par_mode_d;
  reg        ser_mode_d;
  reg        rsv_d;
  reg        to_en_d;
  reg  [1:0] irq_mask_d;
  reg  [1:0] irq_stat_d;
  reg [31:0] rd_d;

  always @* begin
    par_mode_d = par_mode_q;
    ser_mode_d = ser_mode_q;
    rsv_d      = rsv_q;
    to_en_d    = to_en_q;
    irq_mask_d = irq_mask_q;
    if (!armed_q) begin
      par_mode_d = par_sync;
      ser_mode_d = ser_sync;
    end else if (wr_bus_select_register) begin
      ser_mode_d = hwdata[`HPM_SER_MODE_BIT];
      rsv_d      = hwdata[`HPM_RSV_BIT];
    end
    if (wr_to) begin
      to_en_d = hwdata[`HPM_TO_EN_BIT];
    end
    if (wr_mask) begin
      irq_mask_d = hwdata[1:0];
    end
    // set wins over write-one-clear
    irq_stat_d = (irq_stat_q & ~({2{wr_stat}} & hwdata[1:0]))
               | {wr_bus_select_register, err_q & ~err_second_q};
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q    <= 1'b0;
      par_mode_q <= 1'b0;
      ser_mode_q <= 1'b0;
      rsv_q      <= 1'b0;
      to_en_q    <= 1'b0;
      irq_mask_q <= 2'h0;
      irq_stat_q <= 2'h0;
    end else begin
      armed_q    <= 1'b1;
      par_mode_q <= par_mode_d;
      ser_mode_q <= ser_mode_d;
      rsv_q      <= rsv_d;
      to_en_q    <= to_en_d;
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------
  // read data, registered in the address phase
  // ----------------------------------------
  always @* begin
    rd_d = 32'h00000000;
    case (haddr)
      `HPM_BUS_SELECT_ADDR: begin
        rd_d[`HPM_PAR_MODE_BIT] = par_mode_d;
        rd_d[`HPM_SER_MODE_BIT] = ser_mode_d;
        rd_d[`HPM_RSV_BIT]      = rsv_d;
      end
      `HPM_TIMEOUT_ADDR:    rd_d[`HPM_TO_EN_BIT] = to_en_d;
      `HPM_IRQ_STATUS_ADDR: rd_d[1:0] = irq_stat_d;
      `HPM_IRQ_MASK_ADDR:   rd_d[1:0] = irq_mask_d;
      default:              rd_d = 32'h00000000;
    endcase
  end

  // next values used, so a read right after a write sees it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (a_valid & ~hwrite) begin
      hrdata <= rd_d;
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // host and parallel pin routing
  // ----------------------------------------
  assign host_port_enable      = 1'b1;
  assign host_port_multiplexed = par_mode_q;
  assign host_port_on_parallel = ~par_mode_q;
  assign memif_32bit_mode      = par_mode_q;

  always @* begin
    host_port_data_in      = 8'h00;
    host_address_strobe    = 1'b1;
    host_byte_identify     = 1'b0;
    parallel_general_io_in = 10'h000;
    if (par_mode_q) begin
      host_data_pins_out   = host_port_data_out;
      host_data_pins_oe_n  = {8{~host_port_data_drive}};
      host_port_data_in    = host_data_pins_in;
      host_address_strobe  = host_control_pin_zero;
      host_byte_identify   = host_control_pin_one;
    end else begin
      host_data_pins_out     = parallel_general_io_out[7:0];
      host_data_pins_oe_n    = parallel_general_io_oe_n[7:0];
      parallel_general_io_in = {host_control_pin_one,
                                host_control_pin_zero,
                                host_data_pins_in};
    end
  end

  // ----------------------------------------
  // serial port 2 routing
  // ----------------------------------------
  assign serial_port2_enable = ser_mode_q;
  assign uart_enable         = ~ser_mode_q;

  always @* begin
    serial_port2_in     = 4'h0;
    uart_rx             = 1'b1;
    general_io_three_in = 1'b0;
    general_io_five_in  = 1'b0;
    if (ser_mode_q) begin
      serial_pins_out  = {serial_receive_frame_sync_out,
                          serial_transmit_frame_sync_out,
                          serial_receive_clock_out,
                          serial_transmit_clock_out};
      serial_pins_oe_n = {serial_receive_frame_sync_oe_n,
                          serial_transmit_frame_sync_oe_n,
                          serial_receive_clock_oe_n,
                          serial_transmit_clock_oe_n};
      serial_port2_in  = serial_pins_in;
    end else begin
      serial_pins_out  = {1'b1, general_io_five_out,
                          uart_tx, general_io_three_out};
      serial_pins_oe_n = {1'b1, general_io_five_oe_n,
                          1'b0, general_io_three_oe_n};
      uart_rx             = serial_pins_in[3];
      general_io_three_in = serial_pins_in[0];
      general_io_five_in  = serial_pins_in[2];
    end
  end

  // ----------------------------------------
  // module clock gating
  // ----------------------------------------
  hpm_clk_gate u_gate_sp2 (
    .hclk   (hclk),
    .enable (ser_mode_q),
    .gclk   (serial_port2_clk)
  );
  hpm_clk_gate u_gate_uart (
    .hclk   (hclk),
    .enable (~ser_mode_q),
    .gclk   (uart_clk)
  );
  hpm_clk_gate u_gate_memif (
    .hclk   (hclk),
    .enable (par_mode_q),
    .gclk   (memif_clk)
  );
endmodule

// file: tb/hpm_pin_mux_props.sv
`timescale 1ns/1ns
module hpm_pin_mux_props (
  // bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [15:0] haddr,
  input wire [1:0]  htrans,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  // pins and modes
  input wire [7:0]  host_data_pins_in,
  input wire        host_control_pin_zero,
  input wire        host_control_pin_one,
  input wire        host_address_strobe,
  input wire        host_byte_identify,
  input wire        host_port_enable,
  input wire        host_port_multiplexed,
  input wire        host_port_on_parallel,
  input wire [9:0]  parallel_general_io_in,
  input wire        memif_32bit_mode,
  input wire [3:0]  serial_pins_in,
  input wire        uart_rx,
  input wire        serial_port2_enable,
  input wire        uart_enable
);
  // ----------------
  // data phase tracking
  // ----------------
  reg        dp_q;
  reg [15:0] da_q;
  wire       win_on;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      da_q <= 16'h0000;
    end else if (hreadyout) begin
      dp_q <= hsel & hready & htrans[1];
      da_q <= haddr;
    end
  end
  assign win_on = da_q < 16'h7000 ||
                  (da_q[9:8] == 2'h0 && serial_port2_enable) ||
                  (da_q[9:8] == 2'h1 && uart_enable) ||
                  (da_q[9:8] == 2'h2 && memif_32bit_mode);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence err_s;
    hresp && !hreadyout ##1 hresp && hreadyout;
  endsequence
  sequence ok_s;
    !hresp && hreadyout;
  endsequence
  err_shape_a: assert property ($rose(hresp) |-> err_s)
    else $error("bus error not two cycles");
  ok_access_a: assert property (dp_q && win_on |-> ok_s)
    else $error("error on a selected target");
  mode_hold_a: assert property ($past(hresetn, 2) |->
    $stable(memif_32bit_mode) && $stable(serial_port2_enable))
    else $error("mode moved after reset");
  sel_excl_a: assert property (serial_port2_enable != uart_enable)
    else $error("serial and uart both on or off");
  host_mode_a: assert property (host_port_enable &&
    host_port_on_parallel == !memif_32bit_mode &&
    host_port_multiplexed == memif_32bit_mode)
    else $error("host port form wrong");
  par_route_a: assert property (!memif_32bit_mode |->
    parallel_general_io_in == {host_control_pin_one,
    host_control_pin_zero, host_data_pins_in})
    else $error("parallel io routing wrong");
  host_mux_a: assert property (memif_32bit_mode |->
    host_address_strobe == host_control_pin_zero &&
    host_byte_identify == host_control_pin_one &&
    parallel_general_io_in == 10'h000)
    else $error("host control routing wrong");
  uart_rx_a: assert property (uart_enable |->
    uart_rx == serial_pins_in[3])
    else $error("uart receive routing wrong");
endmodule
bind hpm_pin_mux hpm_pin_mux_props u_props (.*);

// file: tb/hpm_far_side.sv
`timescale 1ns/1ns
module hpm_far_side (
  // clock
  input  wire       hclk,
  // device pin drive
  input  wire [7:0] hd_out,
  input  wire [7:0] hd_oe_n,
  input  wire [3:0] sp_out,
  input  wire [3:0] sp_oe_n,
  // wire levels
  output wire [7:0] hd_lvl,
  output wire [3:0] sp_lvl,
  output wire [1:0] hc_lvl
);
  // undriven lines show a pattern that moves every cycle; the control lines move only on a carry into bit 12
  reg [13:0] pat_q = 14'h0000;
  always @(posedge hclk) begin
    pat_q <= pat_q + 14'h1A7;
  end
  assign hd_lvl = (~hd_oe_n & hd_out) | (hd_oe_n & pat_q[7:0]);
  assign sp_lvl = (~sp_oe_n & sp_out) | (sp_oe_n & pat_q[11:8]);
  assign hc_lvl = pat_q[13:12];
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
`include "hpm_defines.vh"
module tb;
  // ----------------
  // signals
  // ----------------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        parallel_mode_strap = 1'b0;
  logic        serial_mode_strap = 1'b0;
  logic        hsel = 1'b1;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] haddr = 16'h0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [41:0] rv = 42'h0;
  logic [31:0] r;
  logic        p, s, e;
  logic [7:0]  es;
  logic [15:0] eh;
  logic [9:0]  hx;
  logic [2:0]  gu;
  int          checks = 0;
  int          failures = 0;
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, irq, hready;
  wire [7:0]   host_data_pins_in, host_data_pins_out, host_data_pins_oe_n;
  wire [7:0]   host_port_data_in;
  wire [9:0]   parallel_general_io_in;
  wire [3:0]   serial_pins_in, serial_pins_out, serial_pins_oe_n;
  wire [3:0]   serial_port2_in;
  wire         host_control_pin_zero, host_control_pin_one;
  wire         host_address_strobe, host_byte_identify, host_port_enable;
  wire         host_port_multiplexed, host_port_on_parallel;
  wire         memif_32bit_mode, uart_rx, uart_enable, serial_port2_enable;
  wire         general_io_three_in, general_io_five_in;
  wire         serial_port2_clk, uart_clk, memif_clk;
  assign hready = hreadyout;
  initial begin
    forever #5 hclk = ~hclk;
  end
  hpm_far_side far (
    .hclk(hclk),
    .hd_out(host_data_pins_out),
    .hd_oe_n(host_data_pins_oe_n),
    .sp_out(serial_pins_out),
    .sp_oe_n(serial_pins_oe_n),
    .hd_lvl(host_data_pins_in),
    .sp_lvl(serial_pins_in),
    .hc_lvl({host_control_pin_one, host_control_pin_zero})
  );
  hpm_pin_mux DUT (
    .*,
    .host_port_data_out(rv[7:0]),
    .host_port_data_drive(rv[8]),
    .parallel_general_io_out(rv[18:9]),
    .parallel_general_io_oe_n(rv[28:19]),
    .serial_transmit_clock_out(rv[29]),
    .serial_receive_clock_out(rv[30]),
    .serial_transmit_frame_sync_out(rv[31]),
    .serial_receive_frame_sync_out(rv[32]),
    .serial_transmit_clock_oe_n(rv[33]),
    .serial_receive_clock_oe_n(rv[34]),
    .serial_transmit_frame_sync_oe_n(rv[35]),
    .serial_receive_frame_sync_oe_n(rv[36]),
    .uart_tx(rv[37]),
    .general_io_three_out(rv[38]),
    .general_io_three_oe_n(rv[39]),
    .general_io_five_out(rv[40]),
    .general_io_five_oe_n(rv[41])
  );
  // ----------------
  // helpers
  // ----------------
  function automatic logic [7:0] sp_exp(input logic [41:0] v, input logic m);
    sp_exp = m ? v[36:29]
               : {1'b1, v[41], 1'b0, v[39], 1'b1, v[40], v[37], v[38]};
  endfunction
  function automatic logic [15:0] hd_exp(input logic [41:0] v, input logic m);
    hd_exp = m ? {{8{~v[8]}}, v[7:0]} : {v[26:19], v[16:9]};
  endfunction
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    e = hresp;
    if (n >= 40) begin
      failures++;
      finish_test;
    end
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    parallel_mode_strap <= p;
    serial_mode_strap <= s;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  task automatic irq_is(input logic x);
    #1;
    check(irq, x);
    @(posedge hclk);
  endtask
  task automatic pins;
    @(posedge hclk);
    rv <= 42'({$urandom, $urandom});
    #1;
    es = sp_exp(rv, s);
    eh = hd_exp(rv, p);
    hx = {host_control_pin_one, host_control_pin_zero, host_data_pins_in};
    gu = {uart_rx, general_io_five_in, general_io_three_in};
    check(serial_pins_oe_n, es[7:4]);
    check(serial_pins_out | es[7:4], es[3:0] | es[7:4]);
    check(host_data_pins_oe_n, eh[15:8]);
    check(host_data_pins_out | eh[15:8], eh[7:0] | eh[15:8]);
    check(parallel_general_io_in, p ? 10'h000 : hx);
    check(host_port_data_in, p ? host_data_pins_in : 8'h00);
    check(serial_port2_in, s ? serial_pins_in : 4'h0);
    check(gu, s ? 3'h4
                : {serial_pins_in[3:2], serial_pins_in[0]});
    check({memif_clk, uart_clk, serial_port2_clk}, {p, !s, s});
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    r = $urandom(72);
    for (int i = 0; i < 4; i++) begin
      p = i[0];
      s = i[1];
      do_reset;
      check({memif_32bit_mode, serial_port2_enable}, {p, s});
      ahb(1'b0, `HPM_BUS_SELECT_ADDR, 32'h0);
      check(r, {29'h0, s, 1'b0, p});
      repeat (6) pins;
      @(posedge hclk);
      ahb(1'b1, `HPM_BUS_SELECT_ADDR,
          {29'h0, s, 1'b0, !p});
      ahb(1'b0, `HPM_BUS_SELECT_ADDR, 32'h0);
      check(r, {29'h0, s, 1'b0, p});
      ahb(1'b1, `HPM_IRQ_MASK_ADDR, 32'h3);
      ahb(1'b1, `HPM_TIMEOUT_ADDR, 32'h1);
      irq_is(1'b1);
      for (int j = 0; j < 3; j++) begin
        ahb(1'b0, 16'h7000 + 16'(j << 8), 32'h0);
        check(e, j == 0 ? !s : j == 1 ? s : !p);
      end
      ahb(1'b0, `HPM_IRQ_STATUS_ADDR, 32'h0);
      check(r, 32'h3);
      ahb(1'b1, `HPM_IRQ_STATUS_ADDR, 32'h3);
      irq_is(1'b0);
      ahb(1'b1, `HPM_TIMEOUT_ADDR, 32'h0);
      ahb(1'b0, s ? 16'h7100 : 16'h7000, 32'h0);
      check(e, 1'b0);
      ahb(1'b0, 16'h6C10, 32'h0);
      check(r, 32'h0);
    end
    finish_test;
  end
endmodule
